// ===== src/twd_cmd_unit.sv
`timescale 1ns/100ps
`default_nettype none

module twd_cmd_unit #(
  parameter int ADDR_W = 16,
  parameter logic [7:0] PART_NUMBER_BYTE = 8'h5a, // arbitrary value
  parameter logic [7:0] VERSION_BYTE = 8'h01 // arbitrary value
) (
  // system clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  // debug link
  input wire logic dbgClk,
  input wire logic dbgDataIn,
  output logic dbgDataOut,
  output logic dbgDataOe,
  // cpu observation
  input wire logic [ADDR_W-1:0] cpuPc,
  input wire logic [ADDR_W-1:0] cpuCodeAddr,
  input wire logic cpuIdle,
  input wire logic powerMode0,
  input wire logic oscStable,
  // cpu control
  output logic cpuStop,
  output logic stepReq,
  output logic instrValid,
  output logic [23:0] instrData,
  output logic [1:0] instrLen,
  output logic instrKeepPc,
  // flash and lock
  input wire logic eraseDone,
  input wire logic debugLockBit,
  output logic eraseStart,
  // configuration byte
  output logic [7:0] debugConfig
);

  twd_link_if lnk ();

  twd_link u_link (
    .dbgClk(dbgClk),
    .rst(rst),
    .dbgDataIn(dbgDataIn),
    .dbgDataOut(dbgDataOut),
    .dbgDataOe(dbgDataOe),
    .lnk(lnk)
  );

  // toggle synchroniser; only the second stage and beyond are read
  logic [`TWD_SYNC_STAGES-1:0] tglSync_q;
  logic tglSeen_q;
  twd_pkg::twd_core_st_t state_q;
  twd_pkg::twd_cmd_t kind_q;
  logic allowed_q;
  logic [15:0] resp_q;
  logic [7:0] cfg_q;
  logic halted_q;
  logic haltCause_q;
  logic lockSeen_q;
  logic lockInit_q;
  logic eraseStart_q;
  logic stepReq_q;
  logic instrValid_q;
  logic [23:0] instrData_q;
  logic [1:0] instrLen_q;
  logic instrKeepPc_q;
  logic [`TWD_BP_SLOTS-1:0] bpEn_q;
  logic [ADDR_W-1:0] bpAddr_q [`TWD_BP_SLOTS];

  assign lnk.respWord = resp_q;
  assign cpuStop = halted_q;
  assign stepReq = stepReq_q;
  assign instrValid = instrValid_q;
  assign instrData = instrData_q;
  assign instrLen = instrLen_q;
  assign instrKeepPc = instrKeepPc_q;
  assign eraseStart = eraseStart_q;
  assign debugConfig = cfg_q;

  // command word fields, stable for the whole sync delay
  wire [7:0] cmdCode = lnk.cmdWord[31:24];
  wire [7:0] data1 = lnk.cmdWord[23:16];
  wire [7:0] data2 = lnk.cmdWord[15:8];
  wire [7:0] data3 = lnk.cmdWord[7:0];
  wire tglNow = tglSync_q[`TWD_SYNC_STAGES-1];
  wire newCmd = tglNow ^ tglSeen_q;
  wire twd_pkg::twd_cmd_t kind = twd_pkg::decode(cmdCode);
  // the length sits in the command code, not in the instruction bytes
  wire [1:0] codeLen = cmdCode[1:0];

  // only erase, status and identity pass while locked
  wire lockPass = (kind == twd_pkg::TWD_C_ERASE) || (kind == twd_pkg::TWD_C_STAT) ||
    (kind == twd_pkg::TWD_C_ID);
  wire allowed = debugLockBit || lockPass;
  wire act = (state_q == twd_pkg::TWD_CS_ACT) && allowed_q;

  // decoded strobes, each valid for the one action cycle
  wire doCfgWr = act && (kind_q == twd_pkg::TWD_C_CFG_WR);
  wire doErase = act && (kind_q == twd_pkg::TWD_C_ERASE);
  wire doHalt = act && (kind_q == twd_pkg::TWD_C_HALT);
  wire doResume = act && (kind_q == twd_pkg::TWD_C_RESUME) && halted_q;
  wire doInject = act && (kind_q == twd_pkg::TWD_C_INJECT) && halted_q;
  wire doStep = act && (kind_q == twd_pkg::TWD_C_STEP) && halted_q;
  wire doSubst = act && (kind_q == twd_pkg::TWD_C_STEPSUB) && halted_q;
  wire doBp = act && (kind_q == twd_pkg::TWD_C_BP);
  wire lockRefresh = act && ((kind_q == twd_pkg::TWD_C_HALT) ||
    (kind_q == twd_pkg::TWD_C_RESUME) || (kind_q == twd_pkg::TWD_C_INJECT) ||
    (kind_q == twd_pkg::TWD_C_STEP) || (kind_q == twd_pkg::TWD_C_STEPSUB));

  // breakpoint match
  logic [`TWD_BP_SLOTS-1:0] bpMatch;
  wire [1:0] bpSlot = data1[`TWD_BP_SLOT_HI:`TWD_BP_SLOT_LO];
  // limitation: resuming on an enabled address halts again at the next edge
  wire anyMatch = (|bpMatch) && !halted_q;

  // status byte, assembled from live inputs and the halt, cause and lock flags
  // the lock bit lags the pin on purpose: hosts expect a cpu command to refresh it
  logic [7:0] statusByte;
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[`TWD_ST_ERASE_DONE] = eraseDone;
    statusByte[`TWD_ST_CPU_IDLE] = cpuIdle;
    statusByte[`TWD_ST_CPU_HALTED] = halted_q;
    statusByte[`TWD_ST_PM0] = powerMode0;
    statusByte[`TWD_ST_HALT_CAUSE] = haltCause_q;
    statusByte[`TWD_ST_LOCKED] = lockSeen_q;
    statusByte[`TWD_ST_OSC_STABLE] = oscStable;
  end

  // answer word, left aligned so the link always starts at bit 15
  // the link picks it up with no handshake: the host's wait before readback
  // outlasts the sync delay and the three core states, so it is settled
  logic [15:0] respNext;
  always_comb
  begin
    respNext = {statusByte, 8'h00};
    if (!allowed_q)
      respNext = 16'h0000;
    else if (kind_q == twd_pkg::TWD_C_CFG_RD)
      respNext = {cfg_q, 8'h00};
    else if (kind_q == twd_pkg::TWD_C_PC_RD)
      respNext = 16'(cpuPc);
    else if (kind_q == twd_pkg::TWD_C_ID)
      respNext = {PART_NUMBER_BYTE, VERSION_BYTE};
  end

  // frozen with the rest; a command that the link takes meanwhile waits for the enable
  // the link holds only one command, so the host must not send a second one then
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tglSync_q <= '0;
    else if (clkEn)
      tglSync_q <= {tglSync_q[`TWD_SYNC_STAGES-2:0], lnk.cmdToggle};
  end

  // command sequencing: catch, act, answer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= twd_pkg::TWD_CS_IDLE;
      tglSeen_q <= 1'b0;
      kind_q <= twd_pkg::TWD_C_NONE;
      allowed_q <= 1'b0;
      resp_q <= `TWD_RESP_RESET;
    end
    else if (clkEn)
    begin
      case (state_q)
        twd_pkg::TWD_CS_IDLE:
        begin
          if (newCmd)
          begin
            tglSeen_q <= tglNow;
            kind_q <= kind;
            allowed_q <= allowed;
            state_q <= twd_pkg::TWD_CS_ACT;
          end
        end
        twd_pkg::TWD_CS_ACT:
          state_q <= twd_pkg::TWD_CS_ANSWER;
        twd_pkg::TWD_CS_ANSWER:
        begin
          // answer taken after the action so status shows its effect
          resp_q <= respNext;
          state_q <= twd_pkg::TWD_CS_IDLE;
        end
        default:
          state_q <= twd_pkg::TWD_CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cfg_q <= `TWD_CFG_RESET;
    else if (clkEn && doCfgWr)
      cfg_q <= data1;
  end

  // cpu run state; set wins, halt command and match both stop the cpu
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      halted_q <= 1'b0;
      haltCause_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (anyMatch)
      begin
        halted_q <= 1'b1;
        haltCause_q <= 1'b1;
      end
      else if (doHalt)
      begin
        halted_q <= 1'b1;
        haltCause_q <= 1'b0;
      end
      else if (doResume)
        halted_q <= 1'b0;
    end
  end

  // lock flag seen by status; caught after reset release, refreshed on cpu commands accepted while unlocked
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lockInit_q <= 1'b0;
      lockSeen_q <= 1'b0;
    end
    else if (clkEn && (!lockInit_q || lockRefresh))
    begin
      lockInit_q <= 1'b1;
      lockSeen_q <= ~debugLockBit;
    end
  end

  // one-cycle strobes towards cpu and flash
  // registered so that every top output leaves straight from a flip-flop
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      eraseStart_q <= 1'b0;
      stepReq_q <= 1'b0;
      instrValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      eraseStart_q <= doErase;
      stepReq_q <= doStep;
      // inject and substitute share the instruction strobe
      instrValid_q <= doInject || doSubst;
    end
  end

  // instruction bytes are held until the next inject or substitute for the cpu to read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      instrData_q <= 24'h000000;
      instrLen_q <= 2'b00;
      instrKeepPc_q <= 1'b0;
    end
    else if (clkEn && (doInject || doSubst))
    begin
      instrLen_q <= codeLen;
      instrData_q <= {data1, data2, data3};
      instrKeepPc_q <= doInject;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TWD_BP_SLOTS; g++)
    begin : gSlot
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          bpEn_q[g] <= 1'b0;
          bpAddr_q[g] <= '0;
        end
        else if (clkEn && doBp && bpSlot == 2'(g))
        begin
          bpEn_q[g] <= data1[`TWD_BP_EN_BIT];
          bpAddr_q[g] <= ADDR_W'({data2, data3});
        end
      end
      assign bpMatch[g] = bpEn_q[g] && (cpuCodeAddr == bpAddr_q[g]);
    end
  endgenerate

  // unknown codes decode to none and drive no strobe
  // status read only answers, no strobe above reacts to it

endmodule

`default_nettype wire

// ===== src/twd_link.sv
`timescale 1ns/100ps
`default_nettype none

module twd_link (
  // link clock and reset
  input wire logic dbgClk,
  input wire logic rst,
  // data pin
  input wire logic dbgDataIn,
  output logic dbgDataOut,
  output logic dbgDataOe,
  // towards the core
  twd_link_if.link lnk
);

  twd_pkg::twd_link_st_t phase_q;
  logic [31:0] rxWord_q;
  logic [31:0] cmdWord_q;
  logic cmdToggle_q;
  logic [2:0] bitCnt_q;
  logic [1:0] byteIdx_q;
  logic [1:0] extra_q;
  logic [4:0] txBits_q;
  logic [4:0] txCnt_q;
  logic loaded_q;
  logic [15:0] txShift_q;

  wire [31:0] rxNext = {rxWord_q[30:0], dbgDataIn};
  wire byteDone = (bitCnt_q == 3'd7);
  wire [1:0] firstExtra = twd_pkg::extraBytes(rxNext[7:0]);
  wire [1:0] needExtra = (byteIdx_q == 2'd0) ? firstExtra : extra_q;
  wire lastByte = byteDone && (byteIdx_q == needExtra);
  // the command byte is the oldest byte shifted in so far
  wire [1:0] nResp = twd_pkg::respBytes(rxNext[{byteIdx_q, 3'b111} -: 8]);
  wire [4:0] firstCode = {(2'd3 - byteIdx_q), 3'b000};

  assign lnk.cmdWord = cmdWord_q;
  assign lnk.cmdToggle = cmdToggle_q;

  always_ff @(negedge dbgClk or posedge rst)
  begin
    if (rst)
    begin
      phase_q <= twd_pkg::TWD_LK_RX;
      rxWord_q <= 32'h00000000;
      cmdWord_q <= 32'h00000000;
      cmdToggle_q <= 1'b0;
      bitCnt_q <= 3'd0;
      byteIdx_q <= 2'd0;
      extra_q <= 2'd0;
      txBits_q <= 5'd0;
      txCnt_q <= 5'd0;
    end
    else if (phase_q == twd_pkg::TWD_LK_RX)
    begin
      // msb first, one to four bytes
      rxWord_q <= rxNext;
      bitCnt_q <= bitCnt_q + 3'd1;
      if (byteDone && byteIdx_q == 2'd0)
        extra_q <= firstExtra;
      if (lastByte)
      begin
        cmdWord_q <= rxNext << firstCode;
        cmdToggle_q <= ~cmdToggle_q;
        byteIdx_q <= 2'd0;
        txCnt_q <= 5'd0;
        txBits_q <= {nResp, 3'b000};
        if (nResp != 2'd0)
          phase_q <= twd_pkg::TWD_LK_TX;
      end
      else if (byteDone)
        byteIdx_q <= byteIdx_q + 2'd1;
    end
    else
    begin
      txCnt_q <= txCnt_q + 5'd1;
      if (txCnt_q == txBits_q - 5'd1)
        phase_q <= twd_pkg::TWD_LK_RX;
    end
  end

  // drive on rising edge; answer word is held static by the core
  always_ff @(posedge dbgClk or posedge rst)
  begin
    if (rst)
    begin
      loaded_q <= 1'b0;
      txShift_q <= 16'h0000;
      dbgDataOut <= 1'b0;
      dbgDataOe <= 1'b0;
    end
    else
    begin
      dbgDataOe <= (phase_q == twd_pkg::TWD_LK_TX);
      if (phase_q != twd_pkg::TWD_LK_TX)
      begin
        loaded_q <= 1'b0;
        dbgDataOut <= 1'b0;
      end
      else if (!loaded_q)
      begin
        loaded_q <= 1'b1;
        dbgDataOut <= lnk.respWord[15];
        txShift_q <= {lnk.respWord[14:0], 1'b0};
      end
      else
      begin
        dbgDataOut <= txShift_q[15];
        txShift_q <= {txShift_q[14:0], 1'b0};
      end
    end
  end

endmodule

`default_nettype wire

// ===== src/twd_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface twd_link_if;
  logic [31:0] cmdWord;
  logic cmdToggle;
  logic [15:0] respWord;

  modport link (
    output cmdWord,
    output cmdToggle,
    input respWord
  );

  modport core (
    input cmdWord,
    input cmdToggle,
    output respWord
  );
endinterface

`default_nettype wire

// ===== src/twd_map.svh
`ifndef TWD_MAP_SVH
`define TWD_MAP_SVH

// command codes
`define TWD_CMD_ERASE 8'h14
`define TWD_CMD_CFG_WR 8'h1d
`define TWD_CMD_CFG_RD 8'h24
`define TWD_CMD_PC_RD 8'h28
`define TWD_CMD_STAT_RD 8'h34
`define TWD_CMD_BP_SET 8'h3b
`define TWD_CMD_HALT 8'h44
`define TWD_CMD_RESUME 8'h4c
`define TWD_CMD_STEP 8'h5c
`define TWD_CMD_ID_RD 8'h68
// upper six bits of the length-carrying codes
`define TWD_CMD_INJECT_HI 6'h15
`define TWD_CMD_STEPSUB_HI 6'h19

// breakpoint control byte fields
`define TWD_BP_SLOT_HI 4
`define TWD_BP_SLOT_LO 3
`define TWD_BP_EN_BIT 2

// status byte bit positions
`define TWD_ST_ERASE_DONE 7
`define TWD_ST_CPU_IDLE 6
`define TWD_ST_CPU_HALTED 5
`define TWD_ST_PM0 4
`define TWD_ST_HALT_CAUSE 3
`define TWD_ST_LOCKED 2
`define TWD_ST_OSC_STABLE 1

// reset values
`define TWD_CFG_RESET 8'h00
`define TWD_RESP_RESET 16'h0000

// synchroniser depth and sizes
`define TWD_SYNC_STAGES 2
`define TWD_BP_SLOTS 4
`define TWD_BITS_PER_BYTE 8

`endif

// ===== src/twd_pkg.sv
`default_nettype none
`include "twd_map.svh"

package twd_pkg;

  typedef enum logic [3:0] {
    TWD_C_NONE = 4'h0,
    TWD_C_ERASE = 4'h1,
    TWD_C_CFG_WR = 4'h2,
    TWD_C_CFG_RD = 4'h3,
    TWD_C_PC_RD = 4'h4,
    TWD_C_STAT = 4'h5,
    TWD_C_BP = 4'h6,
    TWD_C_HALT = 4'h7,
    TWD_C_RESUME = 4'h8,
    TWD_C_INJECT = 4'h9,
    TWD_C_STEP = 4'ha,
    TWD_C_STEPSUB = 4'hb,
    TWD_C_ID = 4'hc
  } twd_cmd_t;

  typedef enum logic [1:0] {
    TWD_LK_RX = 2'b00,
    TWD_LK_TX = 2'b01
  } twd_link_st_t;

  typedef enum logic [1:0] {
    TWD_CS_IDLE = 2'b00,
    TWD_CS_ACT = 2'b01,
    TWD_CS_ANSWER = 2'b10
  } twd_core_st_t;

  function automatic twd_cmd_t decode(input logic [7:0] code);
    twd_cmd_t k;
    k = TWD_C_NONE;
    if (code == `TWD_CMD_ERASE) k = TWD_C_ERASE;
    else if (code == `TWD_CMD_CFG_WR) k = TWD_C_CFG_WR;
    else if (code == `TWD_CMD_CFG_RD) k = TWD_C_CFG_RD;
    else if (code == `TWD_CMD_PC_RD) k = TWD_C_PC_RD;
    else if (code == `TWD_CMD_STAT_RD) k = TWD_C_STAT;
    else if (code == `TWD_CMD_BP_SET) k = TWD_C_BP;
    else if (code == `TWD_CMD_HALT) k = TWD_C_HALT;
    else if (code == `TWD_CMD_RESUME) k = TWD_C_RESUME;
    else if (code == `TWD_CMD_STEP) k = TWD_C_STEP;
    else if (code == `TWD_CMD_ID_RD) k = TWD_C_ID;
    else if (code[7:2] == `TWD_CMD_INJECT_HI && code[1:0] != 2'b00) k = TWD_C_INJECT;
    else if (code[7:2] == `TWD_CMD_STEPSUB_HI && code[1:0] != 2'b00) k = TWD_C_STEPSUB;
    return k;
  endfunction

  // data bytes that follow the command byte
  function automatic logic [1:0] extraBytes(input logic [7:0] code);
    twd_cmd_t k;
    k = decode(code);
    if (k == TWD_C_CFG_WR) return 2'd1;
    else if (k == TWD_C_BP) return 2'd3;
    else if (k == TWD_C_INJECT || k == TWD_C_STEPSUB) return code[1:0];
    return 2'd0;
  endfunction

  // bytes returned to the host
  function automatic logic [1:0] respBytes(input logic [7:0] code);
    twd_cmd_t k;
    k = decode(code);
    if (k == TWD_C_NONE) return 2'd0;
    else if (k == TWD_C_PC_RD || k == TWD_C_ID) return 2'd2;
    return 2'd1;
  endfunction

endpackage

`default_nettype wire

// ===== testbench/twd_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module twd_asserts (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  // link pin
  input wire logic dbgDataOut,
  input wire logic dbgDataOe,
  // lock and cpu control
  input wire logic debugLockBit,
  input wire logic cpuStop,
  input wire logic stepReq,
  input wire logic instrValid,
  input wire logic [1:0] instrLen,
  input wire logic eraseStart,
  input wire logic [7:0] debugConfig
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // lock held past the core's sync delay, so no command in flight predates it
  sequence s_locked;
    !debugLockBit [*6];
  endsequence

  chk_erase_pulse: assert property ((clkEn && eraseStart) |=> !eraseStart)
    else $error("erase start longer than one cycle");
  chk_step_pulse: assert property ((clkEn && stepReq) |=> !stepReq)
    else $error("step request longer than one cycle");
  chk_inject_pulse: assert property ((clkEn && instrValid) |=> !instrValid)
    else $error("instruction valid longer than one cycle");
  chk_step_halted: assert property (stepReq |-> cpuStop)
    else $error("step while cpu running");
  chk_inject_halted: assert property (instrValid |-> cpuStop)
    else $error("instruction issued while cpu running");
  chk_len_valid: assert property (instrValid |-> instrLen != 2'h0)
    else $error("instruction length zero");
  chk_pin_idle: assert property (!dbgDataOe |-> !dbgDataOut)
    else $error("data out high while not driving");
  chk_locked_quiet: assert property (s_locked |-> !stepReq && !instrValid && $stable(debugConfig))
    else $error("locked unit acted on a command");
  chk_clk_freeze: assert property (!clkEn |=> $stable(cpuStop) && $stable(debugConfig))
    else $error("state changed while clock enable low");
endmodule

bind twd_cmd_unit twd_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
  .dbgDataOut(dbgDataOut), .dbgDataOe(dbgDataOe), .debugLockBit(debugLockBit),
  .cpuStop(cpuStop), .stepReq(stepReq), .instrValid(instrValid), .instrLen(instrLen),
  .eraseStart(eraseStart), .debugConfig(debugConfig));

`default_nettype wire

// ===== testbench/twd_cmd_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none

module twd_cmd_unit_tb;
  logic sys_clk, rst, clkEn, dbgClk, dbgDataIn, dbgDataOut, dbgDataOe;
  logic [15:0] cpuPc, cpuCodeAddr, rx;
  logic cpuIdle, powerMode0, oscStable, eraseDone, debugLockBit;
  logic cpuStop, stepReq, instrValid, instrKeepPc, eraseStart;
  logic [23:0] instrData;
  logic [1:0] instrLen;
  logic [7:0] debugConfig;
  int err_total = 0;
  int n_tests = 0;
  int nStep = 0;
  int nInj = 0;
  int nErase = 0;
  int k;

  twd_cmd_unit #(.PART_NUMBER_BYTE(8'hc3), .VERSION_BYTE(8'h07)) DUT (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .dbgClk(dbgClk), .dbgDataIn(dbgDataIn),
    .dbgDataOut(dbgDataOut), .dbgDataOe(dbgDataOe), .cpuPc(cpuPc), .cpuCodeAddr(cpuCodeAddr),
    .cpuIdle(cpuIdle), .powerMode0(powerMode0), .oscStable(oscStable), .cpuStop(cpuStop),
    .stepReq(stepReq), .instrValid(instrValid), .instrData(instrData), .instrLen(instrLen),
    .instrKeepPc(instrKeepPc), .eraseDone(eraseDone), .debugLockBit(debugLockBit),
    .eraseStart(eraseStart), .debugConfig(debugConfig));

  twd_host_model host (.dbgClk(dbgClk), .dbgDataIn(dbgDataIn), .dbgDataOut(dbgDataOut),
    .dbgDataOe(dbgDataOe));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (stepReq === 1'b1) nStep++;
    if (instrValid === 1'b1) nInj++;
    if (eraseStart === 1'b1) nErase++;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [7:0] st(input logic h, input logic c);
    return {eraseDone, cpuIdle, h, powerMode0, c, ~debugLockBit, oscStable, 1'b0};
  endfunction

  initial
  begin
    // the whole sequence needs about 23 us
    #150000;
    err_total++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    clkEn = 1'b1;
    cpuPc = 16'h1234;
    cpuCodeAddr = 16'h0000;
    cpuIdle = 1'b0;
    powerMode0 = 1'b1;
    eraseDone = 1'b1;
    debugLockBit = 1'b1;
    oscStable = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(2);
    host.xfer({8'h1d, 8'ha5, 16'h0}, 2, 1, rx);
    check("cfg status", rx[7:0], st(0, 0));
    check("cfg", debugConfig, 8'ha5);
    host.xfer({8'h24, 24'h0}, 1, 1, rx);
    check("cfg read", rx[7:0], 8'ha5);
    tick(1);
    cpuIdle = 1'b1;
    powerMode0 = 1'b0;
    oscStable = 1'b0;
    host.xfer({8'h34, 24'h0}, 1, 1, rx);
    check("status", {rx[7:0], debugConfig}, {st(0, 0), 8'ha5});
    tick(1);
    cpuIdle = 1'b0;
    powerMode0 = 1'b1;
    oscStable = 1'b1;
    host.xfer({8'h28, 24'h0}, 1, 2, rx);
    check("pc", rx, 16'h1234);
    host.xfer({8'h68, 24'h0}, 1, 2, rx);
    check("id", rx, 16'hc307);
    $display("test reads done");
    host.xfer({8'h44, 24'h0}, 1, 1, rx);
    check("halt", {cpuStop, rx[7:0]}, {1'b1, st(1, 0)});
    // flash writes reach the cpu as injected code
    for (int n = 1; n < 4; n++)
    begin
      k = nInj;
      host.xfer({6'h15, 2'(n), 24'h123456}, n + 1, 1, rx);
      check("inject", nInj, k + 1);
      check("len", {instrLen, instrKeepPc, rx[7:0]}, {2'(n), 1'b1, st(1, 0)});
    end
    check("data", instrData, 24'h123456);
    host.xfer({8'h66, 16'habcd, 8'h0}, 3, 1, rx);
    check("substitute", {instrKeepPc, instrLen, instrData[23:8]}, {3'b010, 16'habcd});
    k = nStep;
    host.xfer({8'h5c, 24'h0}, 1, 1, rx);
    check("step", nStep, k + 1);
    host.xfer({8'h4c, 24'h0}, 1, 1, rx);
    check("resume", {cpuStop, rx[7:0]}, {1'b0, st(0, 0)});
    host.xfer({8'h5c, 24'h0}, 1, 1, rx);
    check("step running", nStep, k + 1);
    k = nInj;
    host.xfer({8'h54, 24'h0}, 1, 0, rx);
    host.xfer({8'hff, 24'h0}, 1, 0, rx);
    check("unknown", {nInj[7:0], cpuStop, debugConfig}, {k[7:0], 1'b0, 8'ha5});
    $display("test cpu control done");
    // three data bytes, control low bits zero
    host.xfer({8'h3b, 8'h14, 16'h0abc}, 4, 1, rx);
    tick(1);
    cpuCodeAddr = 16'h0abc;
    tick(3);
    check("bp halt", cpuStop, 1'b1);
    host.xfer({8'h34, 24'h0}, 1, 1, rx);
    check("bp cause", rx[7:0], st(1, 1));
    tick(1);
    cpuCodeAddr = 16'h0000;
    host.xfer({8'h4c, 24'h0}, 1, 1, rx);
    host.xfer({8'h3b, 8'h10, 16'h0abc}, 4, 1, rx);
    tick(1);
    cpuCodeAddr = 16'h0abc;
    tick(4);
    check("bp off", cpuStop, 1'b0);
    $display("test breakpoint done");
    debugLockBit = 1'b0;
    eraseDone = 1'b0;
    host.xfer({8'h1d, 8'h3c, 16'h0}, 2, 1, rx);
    check("locked cfg", {rx[7:0], debugConfig}, {8'h00, 8'ha5});
    host.xfer({8'h68, 24'h0}, 1, 2, rx);
    check("locked id", rx, 16'hc307);
    k = nErase;
    host.xfer({8'h14, 24'h0}, 1, 1, rx);
    check("erase", nErase, k + 1);
    host.xfer({8'h34, 24'h0}, 1, 1, rx);
    check("erasing", rx[7], 1'b0);
    tick(1);
    eraseDone = 1'b1;
    debugLockBit = 1'b1;
    clkEn = 1'b0;
    // a halt taken by the link while frozen must wait for the enable
    host.xfer({8'h44, 24'h0}, 1, 1, rx);
    check("frozen", cpuStop, 1'b0);
    tick(1);
    clkEn = 1'b1;
    tick(8);
    check("thawed", cpuStop, 1'b1);
    $display("test lock done");
    tick(2);
    complete_run();
  end
endmodule

`default_nettype wire

// ===== testbench/twd_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module twd_host_model (
  // link towards the device
  output logic dbgClk,
  output logic dbgDataIn,
  input wire logic dbgDataOut,
  input wire logic dbgDataOe
);
  logic hostOe = 1'b1;
  logic hostBit = 1'b0;

  // no pull on this pin: a released wire shows the inverse of the last level
  assign dbgDataIn = dbgDataOe ? dbgDataOut : (hostOe ? hostBit : ~hostBit);

  initial
  begin
    dbgClk = 1'b0;
  end

  task automatic xfer(input logic [31:0] tx, input int nb, input int nr,
    output logic [15:0] rx);
    rx = 16'h0000;
    // msb first, change on rise; the first rise also ends the device's drive
    for (int i = 0; i < nb * 8; i++)
    begin
      dbgClk = 1'b1;
      hostOe = 1'b1;
      hostBit = tx[31 - i];
      #15 dbgClk = 1'b0;
      #15;
    end
    if (nr > 0)
    begin
      hostOe = 1'b0;
      // answer needs at least 100 ns before the first readback edge
      #120;
      for (int i = 0; i < nr * 8; i++)
      begin
        dbgClk = 1'b1;
        #15 dbgClk = 1'b0;
        rx = {rx[14:0], dbgDataIn};
        #15;
      end
      // the device drives until the next first rise; any fall now would be a command bit
    end
    // clock stands still between commands while the core acts
    #200;
  endtask
endmodule

`default_nettype wire
